// file: core/sioc_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the IO control bank.
package sioc_pkg;

  // ==========================================================================
  // Address map
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_MODE_CTRL = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_MASK = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_PENDING_FLAGS = 6'h05;
  localparam logic [ADDR_W-1:0] OFS_WIDE_TIMER_MODE = 6'h06;
  localparam logic [ADDR_W-1:0] OFS_IO_SCRATCH_BYTE = 6'h07;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_CLOCK_MODE_CTRL = 8'hf6;
  localparam logic [7:0] RST_IRQ_ENABLE_MASK = 8'h00;
  localparam logic [7:0] RST_IRQ_PENDING_FLAGS = 8'h00;
  localparam logic [7:0] RST_WIDE_TIMER_MODE = 8'h00;
  localparam logic [7:0] RST_IO_SCRATCH_BYTE = 8'h00;

  // ==========================================================================
  // Clock mode fields
  localparam int CM_SEL_HI = 7;
  localparam int CM_SEL_LO = 5;
  localparam int CM_FAST_EN = 4;
  localparam int CM_TYPE = 3;
  localparam int CM_SLOW_EN = 2;
  localparam int CM_WDOG_EN = 1;
  localparam int CM_PIN_RESET = 0;

  // Interrupt source bit positions; the rest read as zero.
  localparam int IRQ_SECOND_TIMER = 6;
  localparam int IRQ_ADC = 3;
  localparam int IRQ_WIDE_TIMER = 2;
  localparam int IRQ_PORT_B_BIT0 = 1;
  localparam int IRQ_PORT_A_BIT0 = 0;
  localparam logic [7:0] IRQ_IMPL_MASK = 8'h4f;

  // Wide timer mode fields.
  localparam int WT_SRC_HI = 7;
  localparam int WT_SRC_LO = 5;
  localparam int WT_PRE_HI = 4;
  localparam int WT_PRE_LO = 3;
  localparam int WT_TAP_HI = 2;
  localparam int WT_TAP_LO = 0;
  localparam int WT_TAP_BASE = 8;

  // ==========================================================================
  // System clock decode
  typedef enum logic [1:0] {
    SIOC_SRC_FAST = 2'h0,
    SIOC_SRC_CRYSTAL = 2'h1,
    SIOC_SRC_SLOW = 2'h2,
    SIOC_SRC_NONE = 2'h3
  } sioc_src_t;

  // Divide ratio as log2: 0 = /1 up to 5 = /32.
  typedef struct packed {
    sioc_src_t src;
    logic [2:0] div_log2;
    logic reserved;
  } sioc_sysclk_t;

  typedef enum logic [2:0] {
    SIOC_WT_OFF = 3'h0,
    SIOC_WT_SYSCLK = 3'h1,
    SIOC_WT_RSV2 = 3'h2,
    SIOC_WT_RSV3 = 3'h3,
    SIOC_WT_FAST = 3'h4,
    SIOC_WT_CRYSTAL = 3'h5,
    SIOC_WT_SLOW = 3'h6,
    SIOC_WT_PORT_A_BIT0 = 3'h7
  } sioc_wt_src_t;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic wr;
    logic rd;
    logic tog;
    logic [2:0] bit_sel;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sioc_io_req_t;

  typedef struct packed {
    sioc_wt_src_t src;
    logic [1:0] prescale;
    logic [2:0] tap;
  } sioc_wt_cfg_t;

endpackage

// file: core/sioc_scratch.sv
// General IO scratch byte with bit toggle and bit-wait status.
`timescale 1ns/10ps
`default_nettype none

module sioc_scratch (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  // Access
  input wire logic wr_en,
  input wire logic tog_en,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  // State
  output logic [7:0] value,
  output logic bit_value
);

  logic [7:0] next_value;

  // A watchdog reset is not wired here, so the byte keeps its contents across it.
  always_comb begin
    next_value = value;
    if (wr_en) begin
      next_value = wdata;
    end else if (tog_en) begin
      next_value[bit_sel] = ~value[bit_sel]; // RULE12
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      value <= sioc_pkg::RST_IO_SCRATCH_BYTE; // RULE11
    end else begin
      value <= next_value;
    end
  end

  assign bit_value = value[bit_sel]; // RULE12

endmodule

`default_nettype wire

// file: core/sioc_regs.sv
// Register bank for clock mode, interrupt enable and request, wide timer mode and scratch byte.
//
// Function
// (RULE1) Clock code bits 7:5, type 0 table: fast/4,/2,/1, crystal/4,/2,/1, slow/4, slow.
// (RULE2) Type 1 table: fast/16, fast/8, fast/32, crystal/8; other codes reserved.
// (RULE3) Clock mode bit 4 enables the fast oscillator, reset value one.
// (RULE4) Bit 2 enables slow oscillator; slow oscillator off also forces watchdog off.
// (RULE5) Bit 1 enables the watchdog, reset value one.
// (RULE6) Bit 0 chooses port bit or active-low reset for the shared pin.
// (RULE7) Enable bits 6,3,2,1,0 for five sources, reset zero; others reserved.
// (RULE8) Request flags share enable positions; hardware sets, software writes zero to clear.
// (RULE9) Timer mode bits 7:5 pick counter clock; bits 4:3 prescale 1,4,16,64.
// (RULE10) Timer bits 2:0 pick counter bit 8..15; rising tap raises timer event.
// (RULE11) Scratch byte cleared by power-on or low-voltage reset, kept on watchdog reset.
// (RULE12) Scratch byte supports wait-low, wait-high and toggle bit operations.
`timescale 1ns/10ps
`default_nettype none

module sioc_regs (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wdog_reset,
  // IO space access from the processor core
  input wire sioc_pkg::sioc_io_req_t io_req,
  input wire logic wait_high,
  output logic [7:0] io_rdata,
  output logic bit_wait_done,
  // Interrupt events from the sources
  input wire logic second_timer_event,
  input wire logic adc_event,
  input wire logic port_b_bit0_event,
  input wire logic port_a_bit0_event,
  input wire logic [15:8] wide_timer_count,
  // Clock and pin control
  output sioc_pkg::sioc_sysclk_t sys_clk_sel,
  output logic fast_internal_osc_en,
  output logic slow_internal_osc_en,
  output logic watchdog_run,
  output logic shared_reset_pin_is_reset,
  // Interrupt state and timer configuration
  output logic [7:0] irq_enable,
  output logic [7:0] irq_pending,
  output logic irq_request,
  output sioc_pkg::sioc_wt_cfg_t wide_timer_cfg
);

  // ==========================================================================
  // Register state
  logic [7:0] clock_mode_ctrl;
  logic [7:0] irq_enable_mask;
  logic [7:0] irq_pending_flags;
  logic [7:0] wide_timer_mode;
  logic tap_prev;
  logic [7:0] next_clock_mode_ctrl;
  logic [7:0] next_irq_enable_mask;
  logic [7:0] next_irq_pending_flags;
  logic [7:0] next_wide_timer_mode;
  logic next_tap_prev;
  logic [7:0] next_io_rdata;
  logic [7:0] scratch_value;
  logic scratch_bit;
  logic [7:0] hw_events;
  logic tap_now;
  logic soft_rst_b;

  // A watchdog timeout resets everything here except the scratch byte.
  assign soft_rst_b = rst_b & ~wdog_reset;

  // ==========================================================================
  // Wide timer tap
  assign tap_now = wide_timer_count[sioc_pkg::WT_TAP_BASE +
    int'(wide_timer_mode[sioc_pkg::WT_TAP_HI:sioc_pkg::WT_TAP_LO])]; // RULE10

  always_comb begin
    hw_events = 8'h00;
    hw_events[sioc_pkg::IRQ_SECOND_TIMER] = second_timer_event;
    hw_events[sioc_pkg::IRQ_ADC] = adc_event;
    hw_events[sioc_pkg::IRQ_WIDE_TIMER] = tap_now & ~tap_prev; // RULE10
    hw_events[sioc_pkg::IRQ_PORT_B_BIT0] = port_b_bit0_event;
    hw_events[sioc_pkg::IRQ_PORT_A_BIT0] = port_a_bit0_event;
  end

  // ==========================================================================
  // Register writes and read data
  always_comb begin
    next_clock_mode_ctrl = clock_mode_ctrl;
    next_irq_enable_mask = irq_enable_mask;
    next_irq_pending_flags = irq_pending_flags;
    next_wide_timer_mode = wide_timer_mode;
    next_tap_prev = tap_now;
    next_io_rdata = io_rdata;
    if (io_req.wr) begin
      unique case (io_req.addr)
        sioc_pkg::OFS_CLOCK_MODE_CTRL: begin
          next_clock_mode_ctrl = io_req.wdata; // RULE1 RULE3 RULE5 RULE6
        end
        sioc_pkg::OFS_IRQ_ENABLE_MASK: begin
          next_irq_enable_mask = io_req.wdata & sioc_pkg::IRQ_IMPL_MASK; // RULE7
        end
        sioc_pkg::OFS_IRQ_PENDING_FLAGS: begin
          next_irq_pending_flags = io_req.wdata & sioc_pkg::IRQ_IMPL_MASK; // RULE8
        end
        sioc_pkg::OFS_WIDE_TIMER_MODE: begin
          next_wide_timer_mode = io_req.wdata; // RULE9
        end
        default: begin
        end
      endcase
    end else if (io_req.tog && io_req.addr != sioc_pkg::OFS_IO_SCRATCH_BYTE) begin
      unique case (io_req.addr)
        sioc_pkg::OFS_CLOCK_MODE_CTRL: begin
          next_clock_mode_ctrl[io_req.bit_sel] = ~clock_mode_ctrl[io_req.bit_sel];
        end
        sioc_pkg::OFS_IRQ_ENABLE_MASK: begin
          next_irq_enable_mask[io_req.bit_sel] = ~irq_enable_mask[io_req.bit_sel];
          next_irq_enable_mask = next_irq_enable_mask & sioc_pkg::IRQ_IMPL_MASK;
        end
        sioc_pkg::OFS_IRQ_PENDING_FLAGS: begin
          next_irq_pending_flags[io_req.bit_sel] = ~irq_pending_flags[io_req.bit_sel];
          next_irq_pending_flags = next_irq_pending_flags & sioc_pkg::IRQ_IMPL_MASK;
        end
        sioc_pkg::OFS_WIDE_TIMER_MODE: begin
          next_wide_timer_mode[io_req.bit_sel] = ~wide_timer_mode[io_req.bit_sel];
        end
        default: begin
        end
      endcase
    end
    // A hardware event in the same cycle as a software clear keeps the flag set.
    next_irq_pending_flags = next_irq_pending_flags | hw_events; // RULE8
    if (io_req.rd) begin
      unique case (io_req.addr)
        sioc_pkg::OFS_CLOCK_MODE_CTRL: next_io_rdata = clock_mode_ctrl;
        sioc_pkg::OFS_IRQ_ENABLE_MASK: next_io_rdata = irq_enable_mask;
        sioc_pkg::OFS_IRQ_PENDING_FLAGS: next_io_rdata = irq_pending_flags;
        sioc_pkg::OFS_WIDE_TIMER_MODE: next_io_rdata = wide_timer_mode;
        sioc_pkg::OFS_IO_SCRATCH_BYTE: next_io_rdata = scratch_value;
        default: next_io_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!soft_rst_b) begin
      clock_mode_ctrl <= sioc_pkg::RST_CLOCK_MODE_CTRL; // RULE1 RULE3 RULE4 RULE5 RULE6
      irq_enable_mask <= sioc_pkg::RST_IRQ_ENABLE_MASK; // RULE7
      irq_pending_flags <= sioc_pkg::RST_IRQ_PENDING_FLAGS;
      wide_timer_mode <= sioc_pkg::RST_WIDE_TIMER_MODE; // RULE10
      // The detector restarts as if the tap were high, so a bit already high is no event.
      tap_prev <= 1'b1; // RULE10
      io_rdata <= 8'h00;
    end else begin
      clock_mode_ctrl <= next_clock_mode_ctrl;
      irq_enable_mask <= next_irq_enable_mask;
      irq_pending_flags <= next_irq_pending_flags;
      wide_timer_mode <= next_wide_timer_mode;
      tap_prev <= next_tap_prev;
      io_rdata <= next_io_rdata;
    end
  end

  // ==========================================================================
  // Scratch byte, reset only by power-on or low-voltage reset
  sioc_scratch u_scratch (
    .core_clk(core_clk),
    .rst_b(rst_b), // RULE11
    .wr_en(io_req.wr && io_req.addr == sioc_pkg::OFS_IO_SCRATCH_BYTE),
    .tog_en(io_req.tog && io_req.addr == sioc_pkg::OFS_IO_SCRATCH_BYTE),
    .bit_sel(io_req.bit_sel),
    .wdata(io_req.wdata),
    .value(scratch_value),
    .bit_value(scratch_bit)
  );

  // Wait-low or wait-high completes when the selected scratch bit matches.
  assign bit_wait_done = (scratch_bit == wait_high); // RULE12

  // ==========================================================================
  // System clock selection decode
  always_comb begin
    sys_clk_sel.reserved = 1'b0;
    sys_clk_sel.src = sioc_pkg::SIOC_SRC_NONE;
    sys_clk_sel.div_log2 = 3'h0;
    if (!clock_mode_ctrl[sioc_pkg::CM_TYPE]) begin
      unique case (clock_mode_ctrl[sioc_pkg::CM_SEL_HI:sioc_pkg::CM_SEL_LO]) // RULE1
        3'h0: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_FAST;
          sys_clk_sel.div_log2 = 3'h2;
        end
        3'h1: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_FAST;
          sys_clk_sel.div_log2 = 3'h1;
        end
        3'h2: sys_clk_sel.src = sioc_pkg::SIOC_SRC_FAST;
        3'h3: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_CRYSTAL;
          sys_clk_sel.div_log2 = 3'h2;
        end
        3'h4: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_CRYSTAL;
          sys_clk_sel.div_log2 = 3'h1;
        end
        3'h5: sys_clk_sel.src = sioc_pkg::SIOC_SRC_CRYSTAL;
        3'h6: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_SLOW;
          sys_clk_sel.div_log2 = 3'h2;
        end
        3'h7: sys_clk_sel.src = sioc_pkg::SIOC_SRC_SLOW;
      endcase
    end else begin
      unique case (clock_mode_ctrl[sioc_pkg::CM_SEL_HI:sioc_pkg::CM_SEL_LO]) // RULE2
        3'h0: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_FAST;
          sys_clk_sel.div_log2 = 3'h4;
        end
        3'h1: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_FAST;
          sys_clk_sel.div_log2 = 3'h3;
        end
        3'h3: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_FAST;
          sys_clk_sel.div_log2 = 3'h5;
        end
        3'h5: begin
          sys_clk_sel.src = sioc_pkg::SIOC_SRC_CRYSTAL;
          sys_clk_sel.div_log2 = 3'h3;
        end
        default: sys_clk_sel.reserved = 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // Control outputs
  assign fast_internal_osc_en = clock_mode_ctrl[sioc_pkg::CM_FAST_EN]; // RULE3
  assign slow_internal_osc_en = clock_mode_ctrl[sioc_pkg::CM_SLOW_EN]; // RULE4
  assign watchdog_run = clock_mode_ctrl[sioc_pkg::CM_WDOG_EN] &
    clock_mode_ctrl[sioc_pkg::CM_SLOW_EN]; // RULE4 RULE5
  assign shared_reset_pin_is_reset = clock_mode_ctrl[sioc_pkg::CM_PIN_RESET]; // RULE6
  assign irq_enable = irq_enable_mask;
  assign irq_pending = irq_pending_flags;
  assign irq_request = |(irq_enable_mask & irq_pending_flags); // RULE7
  always_comb begin
    wide_timer_cfg.src = sioc_pkg::sioc_wt_src_t'(
      wide_timer_mode[sioc_pkg::WT_SRC_HI:sioc_pkg::WT_SRC_LO]); // RULE9
    wide_timer_cfg.prescale = wide_timer_mode[sioc_pkg::WT_PRE_HI:sioc_pkg::WT_PRE_LO]; // RULE9
    wide_timer_cfg.tap = wide_timer_mode[sioc_pkg::WT_TAP_HI:sioc_pkg::WT_TAP_LO]; // RULE10
  end

endmodule

`default_nettype wire

// file: tb/sioc_cpu.sv
// Processor core model that issues IO-space accesses to the control bank.
`timescale 1ns/10ps
`default_nettype none

module sioc_cpu (
  // Clock
  input wire logic core_clk,
  // IO access
  output var sioc_pkg::sioc_io_req_t io_req,
  output var logic wait_high,
  input wire logic [7:0] io_rdata,
  input wire logic bit_wait_done
);
  initial begin
    io_req = '0;
    wait_high = 1'b0;
  end

  // ====================
  // Access
  // One access is held for a cycle, then the idle lines show inverted values.
  task automatic acc(input logic [2:0] k, input logic [5:0] a, input logic [7:0] d,
    input logic [2:0] b, input logic hi, output logic [7:0] q, output logic w);
    @(posedge core_clk);
    #1;
    io_req = {k, b, a, d};
    wait_high = hi;
    @(posedge core_clk);
    #1;
    q = io_rdata;
    w = bit_wait_done;
    io_req = {3'h0, ~b, ~a, ~d};
    wait_high = ~hi;
  endtask
endmodule
`default_nettype wire

// file: tb/sioc_regs_sva.sv
// Assertions on the port behaviour of the IO control bank.
`timescale 1ns/10ps
`default_nettype none

module sioc_regs_sva (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wdog_reset,
  // Access
  input wire sioc_pkg::sioc_io_req_t io_req,
  input wire logic wait_high,
  input wire logic [7:0] io_rdata,
  input wire logic bit_wait_done,
  // Events
  input wire logic second_timer_event,
  input wire logic adc_event,
  input wire logic port_b_bit0_event,
  input wire logic port_a_bit0_event,
  input wire logic [15:8] wide_timer_count,
  // State
  input wire sioc_pkg::sioc_sysclk_t sys_clk_sel,
  input wire logic fast_internal_osc_en,
  input wire logic slow_internal_osc_en,
  input wire logic watchdog_run,
  input wire logic shared_reset_pin_is_reset,
  input wire logic [7:0] irq_enable,
  input wire logic [7:0] irq_pending,
  input wire logic irq_request,
  input wire sioc_pkg::sioc_wt_cfg_t wide_timer_cfg
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  wire logic wr_ok = io_req.wr && !wdog_reset;
  wire logic wr_cm = wr_ok && io_req.addr == sioc_pkg::OFS_CLOCK_MODE_CTRL;
  wire logic wr_ie = wr_ok && io_req.addr == sioc_pkg::OFS_IRQ_ENABLE_MASK;
  wire logic hit_ip = (io_req.wr || io_req.tog) && io_req.addr == sioc_pkg::OFS_IRQ_PENDING_FLAGS;
  wire logic tap0 = wide_timer_cfg.tap == 3'h0;

  property p_code0;
    wr_cm && io_req.wdata[7:5] == 3'h0 && !io_req.wdata[3] |=> sys_clk_sel == 6'h04;
  endproperty
  a_code0: assert property (p_code0) else $error("code zero decode wrong");
  property p_cm_bits;
    wr_cm |=> fast_internal_osc_en == $past(io_req.wdata[4])
      && shared_reset_pin_is_reset == $past(io_req.wdata[0]);
  endproperty
  a_cm_bits: assert property (p_cm_bits) else $error("clock mode bits wrong");
  property p_wd_gate;
    !slow_internal_osc_en |-> !watchdog_run;
  endproperty
  a_wd_gate: assert property (p_wd_gate) else $error("watchdog runs without slow osc");
  property p_wdog_rst;
    wdog_reset |=> watchdog_run && fast_internal_osc_en && irq_enable == 8'h00
      && wide_timer_cfg == 8'h00;
  endproperty
  a_wdog_rst: assert property (p_wdog_rst) else $error("reset values wrong");
  property p_ie;
    wr_ie |=> irq_enable == ($past(io_req.wdata) & 8'h4f);
  endproperty
  a_ie: assert property (p_ie) else $error("enable write wrong");
  property p_set;
    adc_event && !wdog_reset |=> irq_pending[3];
  endproperty
  a_set: assert property (p_set) else $error("request flag not set");
  property p_hold;
    irq_pending[6] && !wdog_reset && !hit_ip |=> $stable(irq_pending[6]);
  endproperty
  a_hold: assert property (p_hold) else $error("request flag lost");
  property p_tap;
    $rose(wide_timer_count[8]) && tap0 && $past(tap0) && $past(rst_b) && !$past(wdog_reset)
      && !wdog_reset |=> irq_pending[2];
  endproperty
  a_tap: assert property (p_tap) else $error("timer tap event missed");

  c_set_clear: cover property (adc_event && hit_ip);
  c_wdog: cover property (wdog_reset ##1 !wdog_reset);
  c_tap: cover property ($rose(wide_timer_count[8]) && tap0);
endmodule

bind sioc_regs sioc_regs_sva sioc_regs_sva_i (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .wdog_reset(wdog_reset),
  .io_req(io_req),
  .wait_high(wait_high),
  .io_rdata(io_rdata),
  .bit_wait_done(bit_wait_done),
  .second_timer_event(second_timer_event),
  .adc_event(adc_event),
  .port_b_bit0_event(port_b_bit0_event),
  .port_a_bit0_event(port_a_bit0_event),
  .wide_timer_count(wide_timer_count),
  .sys_clk_sel(sys_clk_sel),
  .fast_internal_osc_en(fast_internal_osc_en),
  .slow_internal_osc_en(slow_internal_osc_en),
  .watchdog_run(watchdog_run),
  .shared_reset_pin_is_reset(shared_reset_pin_is_reset),
  .irq_enable(irq_enable),
  .irq_pending(irq_pending),
  .irq_request(irq_request),
  .wide_timer_cfg(wide_timer_cfg)
);
`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench of the IO control bank.
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam logic [5:0] CM = sioc_pkg::OFS_CLOCK_MODE_CTRL;
  localparam logic [5:0] IE = sioc_pkg::OFS_IRQ_ENABLE_MASK;
  localparam logic [5:0] IP = sioc_pkg::OFS_IRQ_PENDING_FLAGS;
  localparam logic [5:0] TM = sioc_pkg::OFS_WIDE_TIMER_MODE;
  localparam logic [5:0] SB = sioc_pkg::OFS_IO_SCRATCH_BYTE;
  // Expected clock selection {src, div_log2, reserved} for type 0 then type 1 codes.
  localparam logic [7:0] SEL [16] = '{8'h04, 8'h02, 8'h00, 8'h14, 8'h12, 8'h10, 8'h24, 8'h20,
    8'h08, 8'h06, 8'h31, 8'h0a, 8'h31, 8'h16, 8'h31, 8'h31};
  logic core_clk = 1'b0;
  logic [5:0] drv = 6'h00;
  logic [15:8] wide_timer_count = 8'h00;
  logic [7:0] q, io_rdata, irq_enable, irq_pending;
  logic w, wait_high, bit_wait_done, fast_internal_osc_en, slow_internal_osc_en;
  logic watchdog_run, shared_reset_pin_is_reset, irq_request;
  wire logic rst_b, wdog_reset, second_timer_event, adc_event;
  wire logic port_b_bit0_event, port_a_bit0_event;
  sioc_pkg::sioc_io_req_t io_req;
  sioc_pkg::sioc_sysclk_t sys_clk_sel;
  sioc_pkg::sioc_wt_cfg_t wide_timer_cfg;
  int failures = 0;
  int checked = 0;

  assign {rst_b, wdog_reset, second_timer_event, adc_event, port_b_bit0_event,
    port_a_bit0_event} = drv;
  always #5 core_clk = ~core_clk;

  sioc_regs sioc_regs_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wdog_reset(wdog_reset),
    .io_req(io_req),
    .wait_high(wait_high),
    .io_rdata(io_rdata),
    .bit_wait_done(bit_wait_done),
    .second_timer_event(second_timer_event),
    .adc_event(adc_event),
    .port_b_bit0_event(port_b_bit0_event),
    .port_a_bit0_event(port_a_bit0_event),
    .wide_timer_count(wide_timer_count),
    .sys_clk_sel(sys_clk_sel),
    .fast_internal_osc_en(fast_internal_osc_en),
    .slow_internal_osc_en(slow_internal_osc_en),
    .watchdog_run(watchdog_run),
    .shared_reset_pin_is_reset(shared_reset_pin_is_reset),
    .irq_enable(irq_enable),
    .irq_pending(irq_pending),
    .irq_request(irq_request),
    .wide_timer_cfg(wide_timer_cfg)
  );
  sioc_cpu sioc_cpu_i (
    .core_clk(core_clk),
    .io_req(io_req),
    .wait_high(wait_high),
    .io_rdata(io_rdata),
    .bit_wait_done(bit_wait_done)
  );

  // ====================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic x(input logic [2:0] k, input logic [5:0] a, input logic [7:0] d,
    input logic [2:0] b, input logic hi);
    sioc_cpu_i.acc(k, a, d, b, hi, q, w);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    x(3'h2, a, 8'h00, 3'h0, 1'b0);
    chk(q, e);
  endtask

  // Drives resets and events for one cycle: {rst_b, wdog, second, adc, port b, port a}.
  task automatic pulse(input logic [5:0] p);
    @(posedge core_clk);
    #1;
    drv = p;
    @(posedge core_clk);
    #1;
    drv = 6'h20;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ====================
  // Tests
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    drv = 6'h20;
    rc(CM, 8'hf6);
    rc(IE, 8'h00);
    rc(TM, 8'h00);
    rc(SB, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      x(3'h4, CM, {i[2:0], 1'b1, i[3], 3'h5}, 3'h0, 1'b0);
      chk({2'h0, sys_clk_sel}, SEL[i]);
    end
    chk({6'h0, watchdog_run, shared_reset_pin_is_reset}, 8'h01);
    x(3'h4, CM, 8'h12, 3'h0, 1'b0);
    chk({fast_internal_osc_en, slow_internal_osc_en, watchdog_run}, 8'h04);
    rc(CM, 8'h12);
    $display("test clock mode done");
    x(3'h4, IE, 8'hff, 3'h0, 1'b0);
    rc(IE, 8'h4f);
    pulse(6'h2f);
    rc(IP, 8'h4b);
    chk({7'h0, irq_request}, 8'h01);
    fork
      x(3'h4, IP, 8'h00, 3'h0, 1'b0);
      pulse(6'h24);
    join
    rc(IP, 8'h08);
    x(3'h4, IE, 8'h00, 3'h0, 1'b0);
    chk({7'h0, irq_request}, 8'h00);
    x(3'h1, IE, 8'h00, 3'h7, 1'b0);
    x(3'h1, IE, 8'h00, 3'h3, 1'b0);
    rc(IE, 8'h08);
    chk({7'h0, irq_request}, 8'h01);
    for (int t = 0; t < 8; t++) begin
      x(3'h4, TM, {t[2:0], t[1:0], t[2:0]}, 3'h0, 1'b0);
      chk(wide_timer_cfg, {t[2:0], t[1:0], t[2:0]});
      wide_timer_count = ~(8'h01 << t);
      x(3'h4, IP, 8'h00, 3'h0, 1'b0);
      chk(irq_pending, 8'h00);
      wide_timer_count = 8'hff;
      rc(IP, 8'h04);
    end
    $display("test interrupts and timer done");
    x(3'h4, SB, 8'ha5, 3'h0, 1'b0);
    x(3'h1, SB, 8'h00, 3'h1, 1'b0);
    rc(SB, 8'ha7);
    for (int i = 0; i < 3; i++) begin
      x(3'h0, SB, 8'h00, 3'(i * 6), i != 1);
      chk({7'h0, w}, {7'h0, i < 2});
    end
    pulse(6'h30);
    rc(SB, 8'ha7);
    rc(CM, 8'hf6);
    rc(IP, 8'h00);
    pulse(6'h00);
    rc(SB, 8'h00);
    rc(6'h20, 8'h00);
    $display("test scratch and resets done");
    stop_test();
  end

  initial begin
    #50000;
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
